// ==== hw/gsf_spi_frame.sv ====
// Generic SPI slave moving register words and frame words, with frame header handling.
`timescale 1ns/1ns
module gsf_spi_frame
  import gsf_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire logic                spi_sclk,
  input  wire logic                spi_cs_n,
  input  wire logic                spi_sdi,
  output logic                     spi_sdo,
  output logic                     spi_sdo_oe_n,
  input  wire logic                crc_strap,
  output logic                     crc_enabled,
  output logic                     crc_error,
  output logic                     store_forward_mode,
  output gsf_pkg::gsf_reg_wr_t     reg_wr,
  output logic                     reg_wr_valid,
  output gsf_pkg::gsf_addr_t       reg_rd_addr,
  output logic                     reg_rd_req,
  input  wire gsf_pkg::gsf_word_t  reg_rd_data,
  output gsf_pkg::gsf_word_t       tx_word,
  output logic                     tx_word_valid,
  input  wire gsf_pkg::gsf_word_t  port_receive_word,
  input  wire logic [2:0]          rx_word_bytes,
  output logic                     rx_word_pop,
  input  wire logic                rx_frame_stored,
  input  wire logic                rx_frame_taken,
  output logic                     receive_frame_ready,
  input  wire logic                tx_eof_sent,
  input  wire logic                tx_ready_clear,
  output logic                     tx_ready,
  input  wire logic                tx_stamp_valid,
  input  wire gsf_pkg::gsf_stamp_t tx_stamp,
  output gsf_pkg::gsf_stamp_t      tx_stamp_a,
  output gsf_pkg::gsf_stamp_t      tx_stamp_b,
  output gsf_pkg::gsf_stamp_t      tx_stamp_c,
  output logic [2:0]               stamp_captured,
  input  wire logic [2:0]          stamp_captured_clear,
  input  wire logic                rx_stamp_valid,
  input  wire logic                rx_priority,
  input  wire logic                rx_stamp_present,
  input  wire logic                rx_stamp_long,
  input  wire gsf_pkg::gsf_stamp_t rx_stamp,
  output gsf_pkg::gsf_hdr_t        rx_header
);
  logic [2:0]  sclk_sync_reg, cs_sync_reg, sdi_sync_reg;
  logic        sclk_lvl_reg, sclk_lvl_next, cs_lvl_reg, cs_lvl_next, sdi_lvl_reg, sdi_lvl_next;
  logic        sclk_rise, sclk_fall, field_end, crc_clear, crc_shift, hdr_ok, word_ok;
  logic        emit_now, load_now, is_data_addr;
  gsf_word_t   emit_word;
  gsf_crc_t    crc_val;
  gsf_state_t  state_reg, state_next;
  logic [4:0]  cnt_reg, cnt_next, field_last;
  gsf_word_t   sh_reg, sh_next, wr_word_reg, wr_word_next;
  gsf_word_t   out_sh_reg, out_sh_next, rdata_reg, rdata_next;
  gsf_crc_t    out_crc_reg, out_crc_next;
  gsf_addr_t   addr_reg, addr_next;
  logic        ctl_reg, ctl_next, shift_due_reg, shift_due_next;
  logic        crc_en_reg, crc_en_next, strap_done_reg, strap_done_next;
  logic        rd_pend_reg, rd_pend_next, rd_req_reg, rd_req_next;
  gsf_reg_wr_t reg_wr_reg, reg_wr_next;
  logic        wr_valid_reg, wr_valid_next, crc_err_reg, crc_err_next;
  gsf_word_t   tx_word_reg, tx_word_next;
  logic        tx_valid_reg, tx_valid_next, pop_reg, pop_next;
  logic        hdr_pend_reg, hdr_pend_next, tx_ready_reg, tx_ready_next;
  logic [1:0]  egress_reg, egress_next;
  gsf_stamp_t  stamp_a_reg, stamp_a_next, stamp_b_reg, stamp_b_next;
  gsf_stamp_t  stamp_c_reg, stamp_c_next;
  logic [2:0]  captured_reg, captured_next, captured_set;
  logic [7:0]  rx_cnt_reg, rx_cnt_next;
  gsf_hdr_t    rx_hdr_reg, rx_hdr_next;
  logic        sf_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // A level change counts only once the second and third stages agree.
  function automatic logic settle(input logic [2:0] s, input logic lvl);
    settle = (s[1] == s[2]) ? s[2] : lvl;
  endfunction : settle

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sclk_sync_reg <= '0;
      cs_sync_reg   <= '1;
      sdi_sync_reg  <= '0;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk};
      cs_sync_reg   <= {cs_sync_reg[1:0], spi_cs_n};
      sdi_sync_reg  <= {sdi_sync_reg[1:0], spi_sdi};
    end
  end

  always_comb
  begin
    sclk_lvl_next = settle(sclk_sync_reg, sclk_lvl_reg);
    cs_lvl_next   = settle(cs_sync_reg, cs_lvl_reg);
    sdi_lvl_next  = settle(sdi_sync_reg, sdi_lvl_reg);
    sclk_rise     = sclk_lvl_next && !sclk_lvl_reg;
    sclk_fall     = !sclk_lvl_next && sclk_lvl_reg;
    case (state_reg)
      ST_CMD:             field_last = CMD_LAST;
      ST_WDATA, ST_RDATA: field_last = WORD_LAST;
      ST_SKIP:            field_last = WORD_LAST;
      default:            field_last = BYTE_LAST;
    endcase
    field_end = (cnt_reg == field_last);
    hdr_ok    = (crc8_bit(crc_val, sdi_lvl_reg) == CRC_ZERO);
    word_ok   = hdr_ok;
  end

  gsf_crc8 u_crc_in (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clear    (crc_clear),
    .shift_en (crc_shift),
    .bit_in   (sdi_lvl_reg),
    .crc_out  (crc_val)
  );

  always_comb
  begin
    state_next = state_reg;      cnt_next = cnt_reg;          sh_next = sh_reg;
    wr_word_next = wr_word_reg;  out_sh_next = out_sh_reg;    out_crc_next = out_crc_reg;
    rdata_next = rdata_reg;      addr_next = addr_reg;        ctl_next = ctl_reg;
    shift_due_next = shift_due_reg;
    crc_en_next = crc_en_reg;    strap_done_next = 1'b1;
    rd_pend_next = rd_req_reg;   rd_req_next = 1'b0;          reg_wr_next = reg_wr_reg;
    wr_valid_next = 1'b0;        crc_err_next = 1'b0;         tx_word_next = tx_word_reg;
    tx_valid_next = 1'b0;        pop_next = 1'b0;             hdr_pend_next = hdr_pend_reg;
    egress_next = egress_reg;    crc_clear = 1'b0;            crc_shift = 1'b0;
    emit_now = 1'b0;             load_now = 1'b0;             emit_word = sh_reg;
    is_data_addr = 1'b0;
    // The strap is caught on the first edge after reset releases.
    if (!strap_done_reg)
      crc_en_next = crc_strap;
    if (rd_pend_reg)
      rdata_next = reg_rd_data;
    if (cs_lvl_reg)
    begin
      state_next = ST_IDLE;
      cnt_next = '0;
      out_sh_next = '0;
      shift_due_next = 1'b0;
      crc_clear = 1'b1;
    end
    else if (state_reg == ST_IDLE)
      state_next = ST_CMD;
    else if (sclk_rise)
    begin
      sh_next = {sh_reg[30:0], sdi_lvl_reg};
      cnt_next = cnt_reg + CNT_ONE;
      crc_shift = 1'b1;
      shift_due_next = 1'b1;
      if (field_end)
      begin
        cnt_next = '0;
        case (state_reg)
          ST_CMD:
          begin
            addr_next = sh_next[12:0];
            is_data_addr = (sh_next[12:0] == TX_DATA_ADDR) || (sh_next[12:0] == RX_DATA_ADDR);
            ctl_next = !is_data_addr;
            if (sh_next[CMD_LEAD_HI:CMD_LEAD_LO] != CMD_LEAD)
              state_next = ST_SKIP;
            else if (crc_en_reg)
              state_next = ST_HCRC;
            else
            begin
              state_next = sh_next[CMD_RW] ? ST_WDATA : ST_TA;
              rd_req_next = !sh_next[CMD_RW] && !is_data_addr;
              crc_clear = 1'b1;
            end
          end
          ST_HCRC:
          begin
            crc_clear = 1'b1;
            if (hdr_ok)
            begin
              // The direction bit now sits one whole CRC byte above its header place.
              state_next = sh_next[CMD_RW + $bits(gsf_crc_t)] ? ST_WDATA : ST_TA;
              rd_req_next = !sh_next[CMD_RW + $bits(gsf_crc_t)] && ctl_reg;
            end
            else
            begin
              crc_err_next = 1'b1;
              state_next = ST_SKIP;
            end
          end
          ST_TA:
            load_now = 1'b1;
          ST_WDATA:
          begin
            if (ctl_reg && crc_en_reg)
            begin
              wr_word_next = sh_next;
              state_next = ST_WCRC;
            end
            else
            begin
              emit_now = 1'b1;
              emit_word = sh_next;
            end
          end
          ST_WCRC:
          begin
            crc_clear = 1'b1;
            state_next = ST_WDATA;
            emit_word = wr_word_reg;
            emit_now = word_ok;
            crc_err_next = !word_ok;
          end
          ST_RDATA:
          begin
            if (ctl_reg && crc_en_reg)
            begin
              out_sh_next = {out_crc_reg, 24'h000000};
              shift_due_next = 1'b0;
              state_next = ST_RCRC;
            end
            else
              load_now = 1'b1;
          end
          ST_RCRC:
            load_now = 1'b1;
          default: ;
        endcase
      end
    end
    else if (sclk_fall && shift_due_reg)
    begin
      out_sh_next = {out_sh_reg[30:0], 1'b0};
      shift_due_next = 1'b0;
    end

    if (emit_now && addr_reg == TX_DATA_ADDR)
    begin
      tx_word_next = emit_word;
      tx_valid_next = 1'b1;
      if (hdr_pend_reg)
      begin
        // The frame header sits in the upper half of the first frame word.
        egress_next = emit_word[HDR_IN_WORD + HDR_EGR_HI:HDR_IN_WORD + HDR_EGR_LO];
        hdr_pend_next = 1'b0;
      end
    end
    else if (emit_now)
    begin
      reg_wr_next = '{addr: addr_reg, data: emit_word};
      wr_valid_next = 1'b1;
      if (addr_reg == TX_FSIZE_ADDR)
        hdr_pend_next = 1'b1;
      if (ctl_reg)
        addr_next = addr_reg + ADDR_ONE;
    end
    if (load_now)
    begin
      state_next = ST_RDATA;
      shift_due_next = 1'b0;
      if (ctl_reg)
      begin
        out_sh_next = rdata_reg;
        out_crc_next = crc8_word(rdata_reg);
        addr_next = addr_reg + ADDR_ONE;
        rd_req_next = 1'b1;
      end
      else
      begin
        out_sh_next = pad_word(port_receive_word, rx_word_bytes);
        pop_next = 1'b1;
      end
    end
  end

  always_comb
  begin
    stamp_a_next = stamp_a_reg;
    stamp_b_next = stamp_b_reg;
    stamp_c_next = stamp_c_reg;
    captured_set = '0;
    tx_ready_next = tx_ready_reg;
    if (tx_ready_clear)
      tx_ready_next = 1'b0;
    if (tx_eof_sent)
      tx_ready_next = 1'b1;
    if (tx_stamp_valid)
    begin
      case (egress_reg)
        EGR_A:   stamp_a_next = tx_stamp;
        EGR_B:   stamp_b_next = tx_stamp;
        EGR_C:   stamp_c_next = tx_stamp;
        default: ;
      endcase
      captured_set = {egress_reg == EGR_C, egress_reg == EGR_B, egress_reg == EGR_A};
    end
    // A capture in the same cycle as its clear still leaves the flag set.
    captured_next = (captured_reg & ~stamp_captured_clear) | captured_set;
    rx_cnt_next = rx_cnt_reg;
    if (rx_frame_stored && !rx_frame_taken)
      rx_cnt_next = rx_cnt_reg + RX_CNT_ONE;
    else if (rx_frame_taken && !rx_frame_stored && rx_cnt_reg != '0)
      rx_cnt_next = rx_cnt_reg - RX_CNT_ONE;
    rx_hdr_next = rx_hdr_reg;
    if (rx_stamp_valid)
      rx_hdr_next = make_rx_header(rx_priority, rx_stamp_present, rx_stamp_long, rx_stamp);
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sclk_lvl_reg <= '0;    cs_lvl_reg <= '1;      sdi_lvl_reg <= '0;
      state_reg <= ST_IDLE;  cnt_reg <= '0;         sh_reg <= '0;
      wr_word_reg <= '0;     out_sh_reg <= '0;      out_crc_reg <= CRC_SEED;
      rdata_reg <= '0;       addr_reg <= '0;        ctl_reg <= '0;
      shift_due_reg <= '0;   crc_en_reg <= '0;      strap_done_reg <= '0;
      rd_pend_reg <= '0;     rd_req_reg <= '0;      reg_wr_reg <= '0;
      wr_valid_reg <= '0;    crc_err_reg <= '0;     tx_word_reg <= '0;
      tx_valid_reg <= '0;    pop_reg <= '0;         hdr_pend_reg <= '0;
      egress_reg <= EGR_NONE; tx_ready_reg <= '0;   stamp_a_reg <= '0;
      stamp_b_reg <= '0;     stamp_c_reg <= '0;     captured_reg <= '0;
      rx_cnt_reg <= '0;      rx_hdr_reg <= '0;      sf_reg <= SF_RESET;
    end
    else
    begin
      sclk_lvl_reg <= sclk_lvl_next;   cs_lvl_reg <= cs_lvl_next;   sdi_lvl_reg <= sdi_lvl_next;
      state_reg <= state_next;         cnt_reg <= cnt_next;         sh_reg <= sh_next;
      wr_word_reg <= wr_word_next;     out_sh_reg <= out_sh_next;   out_crc_reg <= out_crc_next;
      rdata_reg <= rdata_next;         addr_reg <= addr_next;       ctl_reg <= ctl_next;
      shift_due_reg <= shift_due_next; crc_en_reg <= crc_en_next;
      strap_done_reg <= strap_done_next;
      rd_pend_reg <= rd_pend_next;     rd_req_reg <= rd_req_next;   reg_wr_reg <= reg_wr_next;
      wr_valid_reg <= wr_valid_next;   crc_err_reg <= crc_err_next; tx_word_reg <= tx_word_next;
      tx_valid_reg <= tx_valid_next;   pop_reg <= pop_next;         hdr_pend_reg <= hdr_pend_next;
      egress_reg <= (tx_stamp_valid && !tx_valid_next) ? EGR_NONE : egress_next;
      tx_ready_reg <= tx_ready_next;   stamp_a_reg <= stamp_a_next; stamp_b_reg <= stamp_b_next;
      stamp_c_reg <= stamp_c_next;     captured_reg <= captured_next;
      rx_cnt_reg <= rx_cnt_next;       rx_hdr_reg <= rx_hdr_next;   sf_reg <= SF_RESET;
    end
  end

  // Undefined fields of a read go out as zeros; only loaded words reach the pin.
  assign spi_sdo             = out_sh_reg[31];
  assign spi_sdo_oe_n        = cs_lvl_reg;
  assign crc_enabled         = crc_en_reg;
  assign crc_error           = crc_err_reg;
  assign store_forward_mode  = sf_reg;
  assign reg_wr              = reg_wr_reg;
  assign reg_wr_valid        = wr_valid_reg;
  assign reg_rd_addr         = addr_reg;
  assign reg_rd_req          = rd_req_reg;
  assign tx_word             = tx_word_reg;
  assign tx_word_valid       = tx_valid_reg;
  assign rx_word_pop         = pop_reg;
  assign receive_frame_ready = (rx_cnt_reg != '0);
  assign tx_ready            = tx_ready_reg;
  assign tx_stamp_a          = stamp_a_reg;
  assign tx_stamp_b          = stamp_b_reg;
  assign tx_stamp_c          = stamp_c_reg;
  assign stamp_captured      = captured_reg;
  assign rx_header           = rx_hdr_reg;

  sequence s_hdr_crc_end;
    state_reg == ST_HCRC && sclk_rise && field_end;
  endsequence
  sequence s_word_crc_end;
    state_reg == ST_WCRC && sclk_rise && field_end;
  endsequence

  a_hdr_crc_drop: assert property (s_hdr_crc_end ##0 !hdr_ok |=> state_reg == ST_SKIP && crc_error) else $error("Bad header CRC not dropped");
  a_word_crc_drop: assert property (s_word_crc_end ##0 !word_ok |=> !reg_wr_valid && crc_error) else $error("Bad word CRC write leaked");
  a_ctl_wr_crc: assert property (reg_wr_valid && crc_enabled |-> $past(state_reg) == ST_WCRC) else $error("Control write without CRC byte");
  a_tx_no_crc: assert property (tx_word_valid |-> state_reg == ST_WDATA && !reg_wr_valid) else $error("Data write word misplaced");
  a_stamp_a: assert property (tx_stamp_valid && egress_reg == EGR_A |=> stamp_captured[0] && tx_stamp_a == $past(tx_stamp)) else $error("Pair A capture missed");
  a_tx_ready_set: assert property (tx_eof_sent |=> tx_ready) else $error("Transmit ready not set");
  a_rx_ready_hold: assert property (rx_frame_taken && !rx_frame_stored && rx_cnt_reg > RX_CNT_ONE |=> receive_frame_ready) else $error("Receive ready dropped with frame left");
  a_rx_parity: assert property (rx_stamp_valid && rx_stamp_present && rx_stamp_long |=> rx_header[HDR_TS_PAR] ^ (^$past(rx_stamp)) && rx_header[HDR_TS_PRES]) else $error("Receive stamp parity not odd");
  a_sdo_quiet: assert property (state_reg inside {ST_CMD, ST_HCRC, ST_TA, ST_WDATA, ST_WCRC} |-> !spi_sdo) else $error("SDO driven outside read data");
  a_sf_mode: assert property (store_forward_mode) else $error("Not in store-and-forward");
endmodule : gsf_spi_frame

// ==== hw/gsf_pkg.sv ====
// Package of constants, types and helpers for the generic SPI frame-transfer block.
// Functional notes
// - Protected control write: 1, 0, R/W, 13-bit address, CRC; each data word gets CRC.
// - Protected control read: header, CRC, turnaround; each returned word followed by CRC.
// - Protected data write: one CRC after header; data words carry no CRC.
// - Protected data read: header, CRC, turnaround, then words without CRC.
// - Every frame over SPI is led by a two-byte frame header.
// - Receive header flag set means a 4 or 8 byte stamp follows header.
// - Nonzero egress capture code records that frame's transmit stamp.
// - After reset both frame paths run store-and-forward.
// - Transmit data header first, first byte in bits 31:24, bursts of words.
// - End-of-frame leaving transmit FIFO sets transmit-ready status.
// - Header: priority bit 10, egress bits 7:6, parity bit 3, present bit 2.
// - Receive priority bit names the queue; host zeroes these bits on transmit.
// - Egress codes 01, 10, 11 select pairs A, B, C and set done flags.
// - Receive header parity is odd parity over the appended stamp.
// - Receive words first byte in bits 31:24; final word zero padded.
// - Receive-ready stays set while another complete frame waits.
// - CRC polynomial x^8+x^2+x+1, seed zero, enabled by strap at power-up.
// - Accesses are whole 32-bit words, most significant bit first.
// - A register write with bad CRC is discarded.
package gsf_pkg;
  typedef logic [31:0] gsf_word_t;
  typedef logic [12:0] gsf_addr_t;
  typedef logic [15:0] gsf_hdr_t;
  typedef logic [7:0]  gsf_crc_t;

  typedef struct packed {
    gsf_word_t high;
    gsf_word_t low;
  } gsf_stamp_t;

  typedef struct packed {
    gsf_addr_t addr;
    gsf_word_t data;
  } gsf_reg_wr_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_HCRC, ST_TA, ST_WDATA, ST_WCRC, ST_RDATA, ST_RCRC, ST_SKIP
  } gsf_state_t;

  localparam logic [4:0] CNT_ONE    = 5'h01;
  localparam logic [4:0] CMD_LAST   = 5'h0f;
  localparam logic [4:0] BYTE_LAST  = 5'h07;
  localparam logic [4:0] WORD_LAST  = 5'h1f;
  localparam logic [1:0] CMD_LEAD   = 2'h2;
  localparam int         CMD_LEAD_HI = 15;
  localparam int         CMD_LEAD_LO = 14;
  localparam int         CMD_RW     = 13;
  localparam gsf_addr_t  ADDR_ONE   = 13'h0001;
  localparam gsf_addr_t  TX_FSIZE_ADDR = 13'h0030;
  localparam gsf_addr_t  TX_DATA_ADDR  = 13'h0031;
  localparam gsf_addr_t  RX_DATA_ADDR  = 13'h0091;
  localparam int         HDR_IN_WORD = 16;
  localparam int         HDR_PRIO   = 10;
  localparam int         HDR_EGR_HI = 7;
  localparam int         HDR_EGR_LO = 6;
  localparam int         HDR_TS_PAR = 3;
  localparam int         HDR_TS_PRES = 2;
  localparam logic [1:0] EGR_NONE   = 2'h0;
  localparam logic [1:0] EGR_A      = 2'h1;
  localparam logic [1:0] EGR_B      = 2'h2;
  localparam logic [1:0] EGR_C      = 2'h3;
  localparam gsf_crc_t   CRC_POLY   = 8'h07;
  localparam gsf_crc_t   CRC_SEED   = 8'h00;
  localparam gsf_crc_t   CRC_ZERO   = 8'h00;
  localparam gsf_word_t  WORD_ONES  = 32'hffffffff;
  localparam logic       SF_RESET   = 1'b1;
  localparam logic [7:0] RX_CNT_ONE = 8'h01;

  function automatic gsf_crc_t crc8_bit(input gsf_crc_t crc, input logic din);
    logic fb;
    fb = crc[7] ^ din;
    crc8_bit = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : CRC_ZERO);
  endfunction : crc8_bit

  function automatic gsf_crc_t crc8_word(input gsf_word_t w);
    gsf_crc_t c;
    c = CRC_SEED;
    for (int i = 31; i >= 0; i--)
      c = crc8_bit(c, w[i]);
    crc8_word = c;
  endfunction : crc8_word

  // A full word is 4 valid bytes; fewer clears the trailing lanes.
  function automatic gsf_word_t pad_word(input gsf_word_t w, input logic [2:0] nbytes);
    pad_word = w & ~(WORD_ONES >> {nbytes, 3'h0});
  endfunction : pad_word

  function automatic gsf_hdr_t make_rx_header(input logic prio, input logic present,
                                              input logic long_stamp, input gsf_stamp_t ts);
    gsf_hdr_t h;
    h = '0;
    h[HDR_PRIO]    = prio;
    h[HDR_TS_PRES] = present;
    if (present)
      h[HDR_TS_PAR] = long_stamp ? ~(^ts) : ~(^ts.low);
    make_rx_header = h;
  endfunction : make_rx_header
endpackage : gsf_pkg

// ==== hw/gsf_crc8.sv ====
// Serial CRC-8 checker for bits arriving on the SPI input.
`timescale 1ns/1ns
module gsf_crc8
  import gsf_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              clear,
  input  wire logic              shift_en,
  input  wire logic              bit_in,
  output gsf_pkg::gsf_crc_t      crc_out
);
  gsf_crc_t crc_reg;
  gsf_crc_t crc_next;

  // Running a field and its own CRC byte through leaves zero when they agree.
  always_comb
  begin
    crc_next = crc_reg;
    if (clear)
      crc_next = CRC_SEED;
    else if (shift_en)
      crc_next = crc8_bit(crc_reg, bit_in);
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      crc_reg <= CRC_SEED;
    else
      crc_reg <= crc_next;
  end

  assign crc_out = crc_reg;

  a_crc_clear: assert property (@(posedge clk_sys) disable iff (reset) clear |=> crc_out == CRC_SEED) else $error("CRC not reseeded");
endmodule : gsf_crc8

// ==== tb/gsf_spi_host.sv ====
// SPI host model: mode-0 transfers, clock held low between frames.
`timescale 1ns/1ns
module gsf_spi_host (
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_sdi,
  input  wire logic spi_sdo
);
  logic [31:0] rd;
  initial
  begin
    {spi_sclk, spi_cs_n, spi_sdi} = 3'h3;
    rd = 32'h0;
  end
  // Sends v[n-1:0] MSB first and takes SDO at each rising edge.
  task automatic shift(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      spi_cs_n = 1'b0;
      spi_sdi = v[i];
      #160 spi_sclk = 1'b1;
      rd = {rd[30:0], spi_sdo};
      #160 spi_sclk = 1'b0;
    end
  endtask : shift
  // A released data line shows the inverse of its last bit.
  task automatic stop();
    #320 spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;
    #2000;
  endtask : stop
endmodule : gsf_spi_host

// ==== tb/tb_generic_spi_frame_transfer.sv ====
// Self-checking bench for the SPI frame-transfer block.
`timescale 1ns/1ns
module tb_generic_spi_frame_transfer;
  import gsf_pkg::*;
  logic clk_sys, reset, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n, crc_strap;
  logic crc_enabled, crc_error, store_forward_mode, reg_wr_valid, reg_rd_req, tx_word_valid;
  logic rx_word_pop, rx_frame_stored, rx_frame_taken, receive_frame_ready, tx_eof_sent;
  logic tx_ready_clear, tx_ready, tx_stamp_valid, rx_stamp_valid, rx_priority;
  logic rx_stamp_present, rx_stamp_long;
  logic [2:0] rx_word_bytes, stamp_captured, stamp_captured_clear;
  gsf_reg_wr_t reg_wr;
  gsf_reg_wr_t wq[$], em[$];
  gsf_addr_t reg_rd_addr, rq[$];
  gsf_word_t reg_rd_data, tx_word, port_receive_word, d;
  gsf_word_t tq[$], et[$];
  gsf_stamp_t tx_stamp, tx_stamp_a, tx_stamp_b, tx_stamp_c, rx_stamp;
  gsf_hdr_t rx_header;
  logic [31:0] seed = 32'h9160;
  int errors = 0, n_compared = 0, ncrc = 0, cyc = 0, npop = 0;
  gsf_spi_frame dut (.*);
  gsf_spi_host host (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] crc(input logic [31:0] v, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = n - 1; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  task automatic pulse(ref logic s);
    tick(1);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask : pulse
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Header, its CRC (optionally corrupted) and, for reads, the turnaround byte.
  task automatic hdr(input logic rw, input logic [12:0] a, input logic bad);
    host.shift({2'b10, rw, a}, 16);
    host.shift(crc({2'b10, rw, a}, 16) ^ {7'h0, bad}, 8);
    if (!rw) host.shift(32'h0, 8);
  endtask : hdr
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  always @(posedge clk_sys)
  begin
    cyc++;
    if (reg_wr_valid === 1'b1) wq.push_back(reg_wr);
    if (tx_word_valid === 1'b1) tq.push_back(tx_word);
    if (crc_error === 1'b1) ncrc++;
    if (reg_rd_req === 1'b1) rq.push_back(reg_rd_addr);
    if (rx_word_pop === 1'b1) npop++;
    if (cyc == 40000)
    begin
      errors++;
      test_done();
    end
  end
  initial
  begin
    {reset, crc_strap, rx_word_bytes} = 5'h1c;
    {rx_frame_stored, rx_frame_taken, tx_eof_sent, tx_ready_clear, tx_stamp_valid} = '0;
    {rx_stamp_valid, rx_priority, rx_stamp_present, rx_stamp_long, stamp_captured_clear} = '0;
    {reg_rd_data, port_receive_word, tx_stamp, rx_stamp} = '0;
    tick(6);
    reset = 1'b0;
    tick(8);
    chk(store_forward_mode, 1);
    chk(crc_enabled, 1);
    hdr(1'b1, 13'h010, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      d = rnd();
      host.shift(d, 32);
      host.shift(crc(d, 32) ^ {7'h0, k == 2}, 8);
      if (k < 2) em.push_back({13'h010 + 13'(k), d});
    end
    host.stop();
    hdr(1'b1, 13'h020, 1'b1);
    host.shift(d, 32);
    host.shift(crc(d, 32), 8);
    host.stop();
    host.shift({3'b111, 13'h012}, 16);
    host.shift(d, 32);
    host.stop();
    chk(ncrc, 2);
    $display("control writes done");
    for (int c = 1; c < 4; c++)
    begin
      hdr(1'b1, 13'h030, 1'b0);
      host.shift(32'h40, 32);
      host.shift(crc(32'h40, 32), 8);
      host.stop();
      em.push_back({13'h030, 32'h40});
      hdr(1'b1, 13'h031, 1'b0);
      et.push_back({8'h00, 2'(c), 6'h00, 16'(rnd())});
      et.push_back(rnd());
      host.shift(et[$ - 1], 32);
      host.shift(et[$], 32);
      host.stop();
      tx_stamp = {rnd(), rnd()};
      pulse(tx_stamp_valid);
      chk(stamp_captured[c - 1], 1);
      chk(c == 1 ? tx_stamp_a : c == 2 ? tx_stamp_b : tx_stamp_c, tx_stamp);
    end
    pulse(tx_eof_sent);
    chk(tx_ready, 1);
    pulse(tx_ready_clear);
    chk(tx_ready, 0);
    stamp_captured_clear = 3'h7;
    tick(1);
    stamp_captured_clear = 3'h0;
    tick(1);
    chk(stamp_captured, 3'h0);
    $display("transmit done");
    reg_rd_data = rnd();
    hdr(1'b0, 13'h011, 1'b0);
    host.shift(32'h0, 32);
    chk(host.rd, reg_rd_data);
    host.shift(32'h0, 8);
    chk(host.rd[7:0], crc(reg_rd_data, 32));
    host.stop();
    chk(rq[0], 13'h011);
    chk(rq[1], 13'h012);
    port_receive_word = rnd();
    rx_word_bytes = 3'h3;
    hdr(1'b0, 13'h091, 1'b0);
    chk(spi_sdo_oe_n, 0);
    host.shift(32'h0, 32);
    chk(host.rd, {port_receive_word[31:8], 8'h00});
    host.stop();
    chk(npop, 2);
    $display("reads done");
    pulse(rx_frame_stored);
    pulse(rx_frame_stored);
    pulse(rx_frame_taken);
    chk(receive_frame_ready, 1);
    pulse(rx_frame_taken);
    chk(receive_frame_ready, 0);
    for (int k = 0; k < 2; k++)
    begin
      {rx_stamp, rx_priority, rx_stamp_long, rx_stamp_present} = {rnd(), rnd(), k[0], k[0], 1'b1};
      pulse(rx_stamp_valid);
      chk(rx_header, {5'h0, k[0], 6'h0, k[0] ? ~^rx_stamp : ~^rx_stamp.low, 3'h4});
    end
    chk(wq.size(), em.size());
    foreach (em[i]) chk(wq[i], em[i]);
    chk(tq.size(), et.size());
    foreach (et[i]) chk(tq[i], et[i]);
    $display("receive done");
    test_done();
  end
endmodule : tb_generic_spi_frame_transfer
